// ---- hdl/data_operand_address_select.sv ----
`timescale 1ns/1ps
module data_operand_address_select
  import opaddr_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // avalon-mm slave
  input  wire logic [3:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  // decode stage request
  input  wire logic                   instr_valid,
  input  wire logic [WORD_W-1:0]      instr_word,
  input  wire logic [WORD_W-1:0]      instr_ext_word,
  // operand answer
  output logic                        op_valid,
  output logic      [2:0]             op_form,
  output logic      [1:0]             op_dest,
  output logic      [DATA_ADDR_W-1:0] op_src_addr,
  output logic      [DATA_ADDR_W-1:0] op_dst_addr,
  output logic      [FIELD_W-1:0]     op_literal,
  output logic      [PROG_ADDR_W-1:0] op_prog_target,
  output logic      [2:0]             op_bit_sel
);

  logic                   extended_set_enable;
  logic [7:0]             access_split;
  logic [7:0]             bank_select_value;
  logic [15:0]            decode_count;
  logic [2:0]             next_form;
  logic [1:0]             next_dest;
  logic [DATA_ADDR_W-1:0] direct_addr;
  logic                   direct_indexed;
  logic [3:0]             group;
  logic                   bus_req;
  logic                   bus_done;
  logic [31:0]            reg_view;

  assign group    = instr_word[GROUP_MSB:GROUP_LSB];
  assign bus_req  = read || write;
  assign bus_done = bus_req && !waitrequest;

  opcode_classifier i_opcode_classifier (
    .instr_word (instr_word),
    .form       (next_form),
    .dest       (next_dest)
  );

  bank_address_builder i_bank_address_builder (
    .field               (instr_word[FIELD_W-1:0]),
    .access_sel          (instr_word[A_BIT]),
    .bank_select_value   (bank_select_value),
    .access_split        (access_split),
    .extended_set_enable (extended_set_enable),
    .data_addr           (direct_addr),
    .indexed             (direct_indexed)
  );

  // bus handshake: one wait cycle, then a single ready cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      waitrequest <= 1'b1;
    else
      waitrequest <= !(bus_req && waitrequest);
  end

  always_comb
  begin
    reg_view = 32'h0000_0000;
    unique case (address)
      OFS_CTRL:
      begin
        reg_view[CTRL_EXT_BIT] = extended_set_enable;
        reg_view[CTRL_SPLIT_LSB +: 8] = access_split;
      end
      OFS_BANK:   reg_view[7:0] = bank_select_value;
      OFS_STATUS: reg_view = {15'h0000, op_dest, op_form, op_src_addr};
      OFS_COUNT:  reg_view[15:0] = decode_count;
      default:    reg_view = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      readdata <= 32'h0000_0000;
    else if (read && waitrequest)
      readdata <= reg_view;
  end

  // configuration writes land at the edge the master sees waitrequest low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      extended_set_enable <= EXT_RESET;
      access_split        <= SPLIT_RESET;
    end
    else if (bus_done && write && address == OFS_CTRL)
    begin
      if (byteenable[0])
        extended_set_enable <= writedata[CTRL_EXT_BIT];
      if (byteenable[1])
        access_split <= writedata[CTRL_SPLIT_LSB +: 8];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      bank_select_value <= BANK_RESET;
    else if (bus_done && write && address == OFS_BANK && byteenable[0])
      bank_select_value <= writedata[7:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      decode_count <= 16'h0000;
    else if (bus_done && write && address == OFS_COUNT)
      decode_count <= 16'h0000;
    else if (instr_valid)
      decode_count <= decode_count + 16'h0001;
  end

  // operand answer, one cycle after the request
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      op_valid <= 1'b0;
    else
      op_valid <= instr_valid;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_form        <= FORM_INHERENT;
      op_dest        <= DEST_NONE;
      op_src_addr    <= '0;
      op_dst_addr    <= '0;
      op_literal     <= '0;
      op_prog_target <= '0;
      op_bit_sel     <= 3'h0;
    end
    else if (instr_valid)
    begin
      op_form        <= next_form;
      op_dest        <= next_dest;
      op_literal     <= '0;
      op_src_addr    <= '0;
      op_dst_addr    <= '0;
      op_prog_target <= '0;
      op_bit_sel     <= 3'h0;
      unique case (next_form)
        FORM_LITERAL:
          op_literal <= instr_word[FIELD_W-1:0];
        FORM_DIRECT:
        begin
          if (direct_indexed)
            op_form <= FORM_INDEXED;
          op_src_addr <= direct_addr;
          op_dst_addr <= direct_addr;
          if (group == GRP_BIT)
            op_bit_sel <= instr_word[BITSEL_MSB:BITSEL_LSB];
        end
        FORM_FULL:
        begin
          op_src_addr <= instr_word[FULL_MSB:0];
          op_dst_addr <= instr_ext_word[FULL_MSB:0];
        end
        FORM_PROGRAM:
          op_prog_target <= {instr_ext_word[FULL_MSB:0], instr_word[FIELD_W-1:0]};
        default:
          op_literal <= '0;
      endcase
    end
  end

  a_bus_one_wait: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req && waitrequest && !$past(bus_done)) |=> !waitrequest)
    else $error("waitrequest did not drop after one wait cycle");

  a_bus_release: assert property (@(posedge clk) disable iff (!rstn)
    bus_done |=> waitrequest)
    else $error("waitrequest stayed low after a completed access");

  a_answer_timing: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid |=> op_valid)
    else $error("operand answer not given one cycle after request");

  a_banked_addr: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BYTE_D && instr_word[A_BIT])
    |=> op_src_addr == {$past(bank_select_value[3:0]), $past(instr_word[7:0])})
    else $error("banked address not built from bank nibble and field");

  a_nibble_place: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BIT && instr_word[A_BIT])
    |=> op_src_addr[11:8] == $past(bank_select_value[3:0])
        && op_bit_sel == $past(instr_word[BITSEL_MSB:BITSEL_LSB]))
    else $error("bank nibble not on address bits 11..8");

  a_access_bank: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BYTE_D && !instr_word[A_BIT])
    |=> op_src_addr[11:8] == ($past(instr_word[7:0]) < $past(access_split)
                              ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK))
    else $error("access bank address depends on bank select");

  a_indexed_gate: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_form == FORM_INDEXED) |-> $past(extended_set_enable))
    else $error("indexed offset form without extension enabled");

  a_full_address: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_FULL_MOV)
    |=> op_src_addr == $past(instr_word[11:0])
        && op_dst_addr == $past(instr_ext_word[11:0]))
    else $error("full address move altered by bank select");

  a_dest_reg: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BYTE_D && instr_word[D_BIT]) |=> op_dest == DEST_REG)
    else $error("result bit one did not target the register");

  a_dest_acc: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BYTE_D && !instr_word[D_BIT])
    ##1 1'b1 |-> op_dest == DEST_ACC && op_valid)
    else $error("result bit zero did not target the accumulator");

  a_implicit_dest: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && (group == GRP_BIT || group == GRP_BYTE_REG)) |=> op_dest == DEST_REG)
    else $error("implicit destination wrong");

  a_literal_path: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && (group == GRP_ADD_LIT || group == GRP_LOAD_LIT))
    |=> op_form == FORM_LITERAL && op_dest == DEST_ACC
        && op_literal == $past(instr_word[7:0]))
    else $error("literal not routed to accumulator");

  a_inherent_none: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_INHERENT)
    |=> op_form == FORM_INHERENT && op_src_addr == '0 && op_literal == '0)
    else $error("inherent form carried an operand");

  a_prog_target: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && (group == GRP_CALL || group == GRP_JUMP))
    |=> op_prog_target == {$past(instr_ext_word[11:0]), $past(instr_word[7:0])})
    else $error("program target not 20 bits from both words");

  a_field_direct: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BYTE_REG) |=> op_src_addr[7:0] == $past(instr_word[7:0]))
    else $error("low opcode byte not used as register address");

  a_dst_follows_src: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BYTE_D && instr_word[D_BIT])
    |=> op_dst_addr == op_src_addr)
    else $error("result register differs from source register");

  a_acc_not_reg: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BYTE_D && !instr_word[D_BIT])
    |=> op_dest != DEST_REG)
    else $error("result bit zero still targets the source register");

  a_bank_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && (group == GRP_BYTE_D || group == GRP_BIT) && !instr_word[A_BIT])
    |=> op_src_addr[11:8] == ACCESS_LOW_BANK || op_src_addr[11:8] == ACCESS_HIGH_BANK)
    else $error("access bank address outside the access bank");

  a_banked_direct: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && (group == GRP_BYTE_D || group == GRP_BYTE_REG) && instr_word[A_BIT])
    |=> op_form == FORM_DIRECT)
    else $error("banked operand reported as indexed");

  a_ext_off: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_BYTE_D && !extended_set_enable)
    |=> op_form == FORM_DIRECT)
    else $error("indexed form while extension disabled");

  a_program_form: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && (group == GRP_CALL || group == GRP_JUMP))
    |=> op_form == FORM_PROGRAM && op_src_addr == '0 && op_literal == '0)
    else $error("program transfer carried a data operand");

  a_illegal_group: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group > GRP_BYTE_REG)
    |=> op_form == FORM_ILLEGAL && op_dest == DEST_NONE && op_src_addr == '0)
    else $error("undefined group not reported as illegal");

  a_valid_idle: assert property (@(posedge clk) disable iff (!rstn)
    !instr_valid
    |=> !op_valid)
    else $error("operand answer without a request");

  a_answer_holds: assert property (@(posedge clk) disable iff (!rstn)
    !instr_valid
    |=> $stable(op_form) && $stable(op_src_addr) && $stable(op_dst_addr))
    else $error("operand answer changed without a request");

  a_full_form: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_FULL_MOV)
    |=> op_form == FORM_FULL)
    else $error("full address move not reported as full form");

  a_decadj_dest: assert property (@(posedge clk) disable iff (!rstn)
    (instr_valid && group == GRP_INHERENT && instr_word[7:0] == SUB_DEC_ADJ)
    |=> op_dest == DEST_ACC)
    else $error("decimal adjust did not target the accumulator");

  a_wait_at_rest: assert property (@(posedge clk) disable iff (!rstn)
    !bus_req
    |=> waitrequest)
    else $error("waitrequest low without a request");

  a_count_clear: assert property (@(posedge clk) disable iff (!rstn)
    (bus_done && write && address == OFS_COUNT)
    |=> decode_count == 16'h0000)
    else $error("count write did not clear the counter");

  a_bank_write: assert property (@(posedge clk) disable iff (!rstn)
    (bus_done && write && address == OFS_BANK && byteenable[0])
    |=> bank_select_value == $past(writedata[7:0]))
    else $error("bank write did not land");

endmodule : data_operand_address_select

// ---- hdl/opaddr_pkg.sv ----
package opaddr_pkg;
  // instruction word layout
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned FIELD_W     = 8;
  localparam int unsigned DATA_ADDR_W = 12;
  localparam int unsigned PROG_ADDR_W = 20;
  localparam int unsigned GROUP_MSB   = 15;
  localparam int unsigned GROUP_LSB   = 12;
  localparam int unsigned D_BIT       = 9;
  localparam int unsigned A_BIT       = 8;
  localparam int unsigned BITSEL_MSB  = 11;
  localparam int unsigned BITSEL_LSB  = 9;
  localparam int unsigned FULL_MSB    = 11;

  // operation groups in the top nibble
  localparam logic [3:0] GRP_INHERENT = 4'h0;
  localparam logic [3:0] GRP_ADD_LIT  = 4'h1;
  localparam logic [3:0] GRP_LOAD_LIT = 4'h2;
  localparam logic [3:0] GRP_BYTE_D   = 4'h3;
  localparam logic [3:0] GRP_BIT      = 4'h4;
  localparam logic [3:0] GRP_FULL_MOV = 4'h5;
  localparam logic [3:0] GRP_CALL     = 4'h6;
  localparam logic [3:0] GRP_JUMP     = 4'h7;
  localparam logic [3:0] GRP_BYTE_REG = 4'h8;
  localparam logic [7:0] SUB_DEC_ADJ  = 8'h07;

  // operand forms reported to the core
  localparam logic [2:0] FORM_INHERENT = 3'h0;
  localparam logic [2:0] FORM_LITERAL  = 3'h1;
  localparam logic [2:0] FORM_DIRECT   = 3'h2;
  localparam logic [2:0] FORM_FULL     = 3'h3;
  localparam logic [2:0] FORM_PROGRAM  = 3'h4;
  localparam logic [2:0] FORM_INDEXED  = 3'h5;
  localparam logic [2:0] FORM_ILLEGAL  = 3'h7;

  // result destinations
  localparam logic [1:0] DEST_NONE = 2'h0;
  localparam logic [1:0] DEST_REG  = 2'h1;
  localparam logic [1:0] DEST_ACC  = 2'h2;

  // access bank halves
  localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // register map, byte addresses
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_BANK   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_COUNT  = 4'hc;
  localparam int unsigned CTRL_EXT_BIT   = 0;
  localparam int unsigned CTRL_SPLIT_LSB = 8;
  localparam logic       EXT_RESET   = 1'b0;
  localparam logic [7:0] SPLIT_RESET = 8'h80;
  localparam logic [7:0] BANK_RESET  = 8'h00;
endpackage : opaddr_pkg

// ---- hdl/opcode_classifier.sv ----
`timescale 1ns/1ps
module opcode_classifier
  import opaddr_pkg::*;
(
  // opcode
  input  wire logic [WORD_W-1:0] instr_word,
  // classification
  output logic      [2:0]        form,
  output logic      [1:0]        dest
);
  logic [3:0] group;
  assign group = instr_word[GROUP_MSB:GROUP_LSB];

  always_comb
  begin
    form = FORM_ILLEGAL;
    dest = DEST_NONE;
    unique case (group)
      GRP_INHERENT:
      begin
        form = FORM_INHERENT;
        dest = (instr_word[7:0] == SUB_DEC_ADJ) ? DEST_ACC : DEST_NONE;
      end
      GRP_ADD_LIT, GRP_LOAD_LIT:
      begin
        form = FORM_LITERAL;
        dest = DEST_ACC;
      end
      GRP_BYTE_D:
      begin
        form = FORM_DIRECT;
        dest = instr_word[D_BIT] ? DEST_REG : DEST_ACC;
      end
      GRP_BIT, GRP_BYTE_REG:
      begin
        form = FORM_DIRECT;
        dest = DEST_REG;
      end
      GRP_FULL_MOV:
      begin
        form = FORM_FULL;
        dest = DEST_REG;
      end
      GRP_CALL, GRP_JUMP:
        form = FORM_PROGRAM;
      default:
        form = FORM_ILLEGAL;
    endcase
  end
endmodule : opcode_classifier

// ---- hdl/bank_address_builder.sv ----
`timescale 1ns/1ps
module bank_address_builder
  import opaddr_pkg::*;
(
  // operand field and selectors
  input  wire logic [FIELD_W-1:0]     field,
  input  wire logic                   access_sel,
  input  wire logic [7:0]             bank_select_value,
  input  wire logic [7:0]             access_split,
  input  wire logic                   extended_set_enable,
  // result
  output logic      [DATA_ADDR_W-1:0] data_addr,
  output logic                        indexed
);
  logic low_half;
  assign low_half = (field < access_split);

  always_comb
  begin
    indexed = 1'b0;
    if (access_sel)
      data_addr = {bank_select_value[3:0], field};
    else
    begin
      data_addr = {(low_half ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK), field};
      indexed   = extended_set_enable && low_half;
    end
  end
endmodule : bank_address_builder

// ---- bench/decode_stage_model.sv ----
`timescale 1ns/1ps
module decode_stage_model
  import opaddr_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // bench request
  input  wire logic              fire,
  input  wire logic [WORD_W-1:0] fire_word,
  input  wire logic [WORD_W-1:0] fire_ext,
  // decode stage outputs
  output logic                   instr_valid,
  output logic      [WORD_W-1:0] instr_word,
  output logic      [WORD_W-1:0] instr_ext_word
);
  // words toggle between requests so no stale opcode can pass for a fresh one
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      instr_valid    <= 1'b0;
      instr_word     <= '0;
      instr_ext_word <= '0;
    end
    else
    begin
      instr_valid    <= fire;
      instr_word     <= fire ? fire_word : ~instr_word;
      instr_ext_word <= fire ? fire_ext : ~instr_ext_word;
    end
  end
endmodule : decode_stage_model

// ---- bench/tb_data_operand_address_select.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_data_operand_address_select
  import opaddr_pkg::*;
;
  logic        clk, rstn, read, write, fire, instr_valid, op_valid;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q, r, rnd_state;
  logic        waitrequest, extended_set_enable;
  logic [15:0] fw, fe, instr_word, instr_ext_word, w;
  logic [2:0]  op_form, op_bit_sel;
  logic [1:0]  op_dest;
  logic [11:0] op_src_addr, op_dst_addr;
  logic [7:0]  op_literal, bank_select_value, access_split;
  logic [19:0] op_prog_target;
  int          failures, check_count, sent;

  data_operand_address_select i_data_operand_address_select (.clk, .rstn, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .instr_valid, .instr_word,
    .instr_ext_word, .op_valid, .op_form, .op_dest, .op_src_addr, .op_dst_addr, .op_literal,
    .op_prog_target, .op_bit_sel);
  decode_stage_model i_decode_stage_model (.clk, .rstn, .fire, .fire_word(fw), .fire_ext(fe),
    .instr_valid, .instr_word, .instr_ext_word);

  function automatic logic [31:0] rnd();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction : rnd

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    write      <= wr;
    read       <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 8);
    if (waitrequest !== 1'b0)
    begin
      failures++;
      stop_test();
    end
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus

  task automatic issue(input logic [15:0] wd, input logic [15:0] e);
    logic [2:0]  f, b;
    logic [1:0]  d;
    logic [11:0] s, t;
    logic [7:0]  l;
    logic [19:0] p;
    logic [3:0]  g;
    logic        low;
    int          n;
    g = wd[15:12];
    low = !wd[8] && wd[7:0] < access_split;
    f = FORM_ILLEGAL;
    d = DEST_NONE;
    s = '0;
    t = '0;
    l = '0;
    p = '0;
    b = '0;
    case (g)
      GRP_INHERENT: d = (wd[7:0] == SUB_DEC_ADJ) ? DEST_ACC : DEST_NONE;
      GRP_ADD_LIT, GRP_LOAD_LIT: l = wd[7:0];
      GRP_FULL_MOV: {s, t} = {wd[11:0], e[11:0]};
      GRP_CALL, GRP_JUMP: p = {e[11:0], wd[7:0]};
      GRP_BYTE_D, GRP_BIT, GRP_BYTE_REG:
      begin
        f = (extended_set_enable && low) ? FORM_INDEXED : FORM_DIRECT;
        s = {low ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, wd[7:0]};
        if (wd[8])
          s = {bank_select_value[3:0], wd[7:0]};
        t = s;
        d = (g != GRP_BYTE_D || wd[9]) ? DEST_REG : DEST_ACC;
        b = (g == GRP_BIT) ? wd[11:9] : 3'h0;
      end
      default: ;
    endcase
    if (g == GRP_INHERENT)
      f = FORM_INHERENT;
    if (g == GRP_ADD_LIT || g == GRP_LOAD_LIT)
      {f, d} = {FORM_LITERAL, DEST_ACC};
    if (g == GRP_FULL_MOV)
      f = FORM_FULL;
    if (g == GRP_CALL || g == GRP_JUMP)
      f = FORM_PROGRAM;
    @(posedge clk);
    fire <= 1'b1;
    fw   <= wd;
    fe   <= e;
    @(posedge clk);
    fire <= 1'b0;
    sent++;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (op_valid !== 1'b1 && n < 4);
    `CHK("op_valid", 1'b1, op_valid)
    `CHK("op_form", f, op_form)
    `CHK("op_src_addr", s, op_src_addr)
    `CHK("op_literal", l, op_literal)
    `CHK("op_bit_sel", b, op_bit_sel)
    if (g < GRP_FULL_MOV || g > GRP_JUMP)
      `CHK("op_dest", d, op_dest)
    `CHK("op_dst_addr", t, op_dst_addr)
    `CHK("op_prog_target", p, op_prog_target)
    @(negedge clk);
    `CHK("op_valid pulse", 1'b0, op_valid)
    bus(1'b0, OFS_STATUS, 32'h0, 4'hf, q);
    `CHK("status", {f, s}, q[14:0])
  endtask : issue

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    {rstn, read, write, fire, address, byteenable, writedata, fw, fe} = '0;
    {failures, check_count, sent} = '0;
    rnd_state = 32'hcb33;
    {extended_set_enable, access_split, bank_select_value} = {EXT_RESET, SPLIT_RESET, BANK_RESET};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, OFS_CTRL, 32'h0, 4'hf, q);
    `CHK("ctrl reset", 32'h00008000, q)
    bus(1'b0, 4'h2, 32'h0, 4'hf, q);
    `CHK("unmapped", 32'h0, q)
    bus(1'b1, OFS_STATUS, 32'hffffffff, 4'hf, q);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hf, q);
    `CHK("status ro", 32'h0, q)
    bus(1'b1, OFS_CTRL, 32'h00001101, 4'h1, q);
    bus(1'b0, OFS_CTRL, 32'h0, 4'hf, q);
    `CHK("ctrl lanes", 32'h00008001, q)
    extended_set_enable = 1'b1;
    bus(1'b1, OFS_BANK, 32'h2, 4'h1, q);
    bank_select_value = 8'h02;
    bus(1'b1, OFS_COUNT, 32'h0, 4'hf, q);
    for (int i = 0; i < 16; i++)
      issue({4'h3, 4'(i), 8'h7f}, 16'h0);
    for (int i = 0; i < 8; i++)
    begin
      w = (i < 4) ? 16'h3345 : 16'h3080;
      issue(w ^ 16'(i << 8), 16'h0);
    end
    issue(16'h0007, 16'h0);
    for (int i = 0; i < 150; i++)
    begin
      q = rnd();
      if (i % 8 == 0)
      begin
        bus(1'b1, OFS_BANK, q, 4'hf, r);
        bank_select_value = q[7:0];
        q = rnd();
        bus(1'b1, OFS_CTRL, q, 4'h3, r);
        {access_split, extended_set_enable} = {q[15:8], q[0]};
        q = rnd();
      end
      issue({4'(q[31:28] % 4'ha), q[11:0]}, q[27:12]);
    end
    bus(1'b0, OFS_COUNT, 32'h0, 4'hf, q);
    `CHK("count", 32'(sent), q)
    stop_test();
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule : tb_data_operand_address_select
